// File: hdl/cls_status.sv
// protocol status register, error-type recording and status-change indication
`timescale 1ns/1ns
`include "cls_consts.svh"

// What this block does
// - three-bit error-type field, resets to zero
// - error-free frame clears error-type to zero
// - software may store unused code seven
// - stuff fault records code one
// - format fault records code two
// - missing acknowledge records code three
// - recessive drive seen dominant records four
// - dominant drive seen recessive records five
// - busoff recovery eleven-recessive run records five
// - checksum mismatch records code six
// - transmit-success flag at bit three
// - only software clears transmit-success flag
// - acknowledged error-free transmit sets the flag
// - enabled status changes raise status interrupt
// - software status writes never raise interrupt
// - status read clears status interrupt indication
module cls_status (
	input  wire logic                 ref_clk_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 hsel_in,
	input  wire logic [31:0]          haddr_in,
	input  wire logic [1:0]           htrans_in,
	input  wire logic                 hwrite_in,
	input  wire logic [2:0]           hsize_in,
	input  wire logic [31:0]          hwdata_in,
	input  wire logic                 hready_in,
	output logic      [31:0]          hrdata_out,
	output logic                      hreadyout_out,
	output logic                      hresp_out,
	input  cls_pkg::cls_event_type    core_event_in,
	output cls_pkg::cls_status_type   status_out,
	output logic                      status_change_irq_out
);
	import cls_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// state

	cls_status_type   status_q;
	cls_status_type   status_d;
	logic             sie_q;
	logic             sie_d;
	logic             irq_pend_q;
	logic             irq_pend_d;
	logic             wr_pend_q;
	logic             wr_pend_d;
	logic [31:0]      wr_addr_q;
	logic [31:0]      wr_addr_d;
	logic [31:0]      hrdata_q;
	logic [31:0]      hrdata_d;
	logic             hreadyout_q;

	cls_err_code_type err_code;
	logic             err_valid;
	logic             addr_take;
	logic             rd_take;
	logic             wr_status;
	logic             wr_control;
	logic             rd_clears_irq;
	logic             hw_status_event;

	// register decode is needed for both the read and the write path
	function automatic logic is_addr(input logic [31:0] a, input logic [31:0] reg_addr);
		is_addr = (a == reg_addr);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// fault encoding

	cls_err_encode cls_err_encode_inst (
		.ev_in     (core_event_in),
		.code_out  (err_code),
		.valid_out (err_valid)
	);

	////////////////////////////////////////////////////////////////////////////
	// bus slave: zero wait states, always OKAY

	always_comb begin
		addr_take  = hsel_in && hready_in && htrans_in[`CLS_HTRANS_NONSEQ_BIT];
		rd_take    = addr_take && !hwrite_in;
		wr_pend_d  = addr_take && hwrite_in;
		wr_addr_d  = addr_take ? haddr_in : wr_addr_q;
		wr_status  = wr_pend_q && is_addr(wr_addr_q, `CLS_ADDR_STATUS);
		wr_control = wr_pend_q && is_addr(wr_addr_q, `CLS_ADDR_CONTROL);
		rd_clears_irq = rd_take && is_addr(haddr_in, `CLS_ADDR_STATUS);
	end

	////////////////////////////////////////////////////////////////////////////
	// status register next value

	always_comb begin
		status_d = status_q;
		sie_d    = sie_q;
		if (wr_control) begin
			sie_d = hwdata_in[`CLS_SIE_BIT];
		end
		// software write stores any code, seven included
		if (wr_status) begin
			status_d.error_type_field      = cls_err_code_type'(hwdata_in[`CLS_ERR_MSB:`CLS_ERR_LSB]);
			status_d.transmit_success_flag = hwdata_in[`CLS_TX_OK_BIT];
			status_d.receive_success_flag  = hwdata_in[`CLS_RX_OK_BIT];
		end
		// hardware sets win over a software clear in the same cycle
		if (core_event_in.tx_done_acked) begin
			status_d.transmit_success_flag = 1'b1;
		end
		if (core_event_in.rx_done_ok) begin
			status_d.receive_success_flag = 1'b1;
		end
		if (core_event_in.tx_done_acked || core_event_in.rx_done_ok) begin
			status_d.error_type_field = CLS_ERR_NONE;
		end
		// a fault in the same cycle is the newer news and wins over the clear
		if (err_valid) begin
			status_d.error_type_field = err_code;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status-change indication

	always_comb begin
		// only protocol events count; software writes are not events here
		hw_status_event = err_valid || core_event_in.tx_done_acked || core_event_in.rx_done_ok;
		irq_pend_d = irq_pend_q;
		if (rd_clears_irq) begin
			irq_pend_d = 1'b0;
		end
		// a new event in the clearing cycle is kept
		if (hw_status_event && sie_q) begin
			irq_pend_d = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data, status and control taken from next values so a write just before is seen

	always_comb begin
		hrdata_d = hrdata_q;
		if (rd_take) begin
			hrdata_d = `CLS_WORD_ZERO;
			if (is_addr(haddr_in, `CLS_ADDR_STATUS)) begin
				hrdata_d[`CLS_ERR_MSB:`CLS_ERR_LSB] = status_d.error_type_field;
				hrdata_d[`CLS_TX_OK_BIT]            = status_d.transmit_success_flag;
				hrdata_d[`CLS_RX_OK_BIT]            = status_d.receive_success_flag;
			end else if (is_addr(haddr_in, `CLS_ADDR_CONTROL)) begin
				hrdata_d[`CLS_SIE_BIT] = sie_d;
			end else if (is_addr(haddr_in, `CLS_ADDR_INT_ID)) begin
				hrdata_d = irq_pend_q ? `CLS_INT_ID_STATUS : `CLS_WORD_ZERO;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_q.error_type_field      <= CLS_ERR_NONE;
			status_q.transmit_success_flag <= 1'b0;
			status_q.receive_success_flag  <= 1'b0;
			sie_q       <= 1'b0;
			irq_pend_q  <= 1'b0;
			wr_pend_q   <= 1'b0;
			wr_addr_q   <= `CLS_WORD_ZERO;
			hrdata_q    <= `CLS_WORD_ZERO;
			hreadyout_q <= 1'b0;
		end else begin
			status_q    <= status_d;
			sie_q       <= sie_d;
			irq_pend_q  <= irq_pend_d;
			wr_pend_q   <= wr_pend_d;
			wr_addr_q   <= wr_addr_d;
			hrdata_q    <= hrdata_d;
			hreadyout_q <= 1'b1;
		end
	end

	always_comb begin
		hrdata_out            = hrdata_q;
		hreadyout_out         = hreadyout_q;
		hresp_out             = `CLS_HRESP_OKAY;
		status_out            = status_q;
		status_change_irq_out = irq_pend_q;
	end

endmodule

// File: hdl/cls_consts.svh
// constants for the protocol status block: offsets, fields, reset values
`ifndef CLS_CONSTS_SVH
`define CLS_CONSTS_SVH

`define CLS_ADDR_CONTROL      32'h40050000
`define CLS_ADDR_STATUS       32'h40050004
`define CLS_ADDR_INT_ID       32'h40050010

`define CLS_ERR_LSB           0
`define CLS_ERR_MSB           2
`define CLS_TX_OK_BIT         3
`define CLS_RX_OK_BIT         4
`define CLS_SIE_BIT           2

`define CLS_ERR_RESET         3'h0
`define CLS_ERR_UNUSED        3'h7
`define CLS_INT_ID_STATUS     32'h00008000
`define CLS_WORD_ZERO         32'h00000000
`define CLS_HTRANS_NONSEQ_BIT 1
`define CLS_HRESP_OKAY        1'h0

`endif

// File: hdl/cls_pkg.sv
// types shared by the protocol status block
package cls_pkg;

	// error-type encodings held in the status register
	typedef enum logic [2:0] {
		CLS_ERR_NONE      = 3'b000,
		CLS_ERR_STUFF     = 3'b001,
		CLS_ERR_FORMAT    = 3'b010,
		CLS_ERR_NO_ACK    = 3'b011,
		CLS_ERR_REC_DRIVE = 3'b100,
		CLS_ERR_DOM_DRIVE = 3'b101,
		CLS_ERR_CHECKSUM  = 3'b110,
		CLS_ERR_UNUSED    = 3'b111
	} cls_err_code_type;

	// one-cycle event pulses from the protocol core, same clock
	typedef struct packed {
		logic rx_done_ok;
		logic tx_done_acked;
		logic stuff_fault;
		logic format_fault;
		logic no_acknowledge_fault;
		logic recessive_drive_fault;
		logic dominant_drive_fault;
		logic busoff_recessive_run;
		logic checksum_fault;
	} cls_event_type;

	// status register view
	typedef struct packed {
		logic             receive_success_flag;
		logic             transmit_success_flag;
		cls_err_code_type error_type_field;
	} cls_status_type;

endpackage

// File: hdl/cls_err_encode.sv
// encodes protocol fault pulses into one error-type code
`timescale 1ns/1ns
module cls_err_encode (
	input  cls_pkg::cls_event_type    ev_in,
	output cls_pkg::cls_err_code_type code_out,
	output logic                      valid_out
);
	import cls_pkg::*;

	// fixed priority when faults coincide; the unused code is never produced
	always_comb begin
		code_out  = CLS_ERR_NONE;
		valid_out = 1'b1;
		if (ev_in.checksum_fault) begin
			code_out = CLS_ERR_CHECKSUM;
		end else if (ev_in.dominant_drive_fault || ev_in.busoff_recessive_run) begin
			code_out = CLS_ERR_DOM_DRIVE;
		end else if (ev_in.recessive_drive_fault) begin
			code_out = CLS_ERR_REC_DRIVE;
		end else if (ev_in.no_acknowledge_fault) begin
			code_out = CLS_ERR_NO_ACK;
		end else if (ev_in.format_fault) begin
			code_out = CLS_ERR_FORMAT;
		end else if (ev_in.stuff_fault) begin
			code_out = CLS_ERR_STUFF;
		end else begin
			valid_out = 1'b0;
		end
	end

endmodule

// File: sim/cls_status_asserts.sv
// concurrent checks on the protocol status block ports
`timescale 1ns/1ns
`include "cls_consts.svh"
module cls_status_asserts
	import cls_pkg::*;
(
	input wire logic               ref_clk_in,
	input wire logic               rst_n_in,
	input wire logic               hsel_in,
	input wire logic [31:0]        haddr_in,
	input wire logic [1:0]         htrans_in,
	input wire logic               hwrite_in,
	input wire logic               hready_in,
	input cls_pkg::cls_event_type  core_event_in,
	input cls_pkg::cls_status_type status_out,
	input wire logic               status_change_irq_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic [8:0]       ev = core_event_in;
	wire cls_err_code_type err = status_out.error_type_field;
	wire logic             st = hsel_in && hready_in && htrans_in[1] && haddr_in == `CLS_ADDR_STATUS;
	////////////////////////////////////////////////////////////////
	property p_stuff; ev == 9'h040 |=> err == CLS_ERR_STUFF; endproperty
	a_stuff: assert property (p_stuff) else $error("stuff code wrong");
	property p_noack; ev == 9'h010 |=> err == CLS_ERR_NO_ACK; endproperty
	a_noack: assert property (p_noack) else $error("no-ack code wrong");
	property p_dom; ev == 9'h004 |=> err == CLS_ERR_DOM_DRIVE; endproperty
	a_dom: assert property (p_dom) else $error("dominant drive code wrong");
	property p_run; ev == 9'h002 |=> err == CLS_ERR_DOM_DRIVE; endproperty
	a_run: assert property (p_run) else $error("busoff run code wrong");
	property p_crc; ev == 9'h001 |=> err == CLS_ERR_CHECKSUM; endproperty
	a_crc: assert property (p_crc) else $error("checksum code wrong");
	property p_ok; ev[6:0] == 7'h0 && ev[8:7] != 2'h0 |=> err == CLS_ERR_NONE; endproperty
	a_ok: assert property (p_ok) else $error("success left code");
	property p_txset; ev[7] |=> status_out.transmit_success_flag; endproperty
	a_txset: assert property (p_txset) else $error("tx flag not set");
	// the write lands one data phase after the address is taken
	property p_txclr; $fell(status_out.transmit_success_flag) |-> $past(st && hwrite_in, 2); endproperty
	a_txclr: assert property (p_txclr) else $error("tx flag cleared by hardware");
	property p_quiet; $rose(status_change_irq_out) |-> $past(ev != 9'h0); endproperty
	a_quiet: assert property (p_quiet) else $error("irq without event");
	property p_rdclr; st && !hwrite_in && ev == 9'h0 |=> !status_change_irq_out; endproperty
	a_rdclr: assert property (p_rdclr) else $error("status read kept irq");
	c_irq: cover property ($rose(status_change_irq_out));
	c_seven: cover property (err == CLS_ERR_UNUSED);
	c_txclr: cover property ($fell(status_out.transmit_success_flag));
endmodule

// File: sim/cls_core_model.sv
// protocol core stand-in that issues one-cycle event pulses
`timescale 1ns/1ns
module cls_core_model
	import cls_pkg::*;
(
	input  wire logic              ref_clk_in,
	output cls_pkg::cls_event_type ev_out
);
	initial ev_out = '0;
	// the core counts the eleven-bit runs itself and only pulses here
	task pulse(input int idx);
		@(posedge ref_clk_in);
		ev_out <= cls_event_type'(9'h001 << idx);
		@(posedge ref_clk_in);
		ev_out <= '0;
	endtask
endmodule

// File: sim/cls_status_bench.sv
// self-checking bench for the protocol status block
`timescale 1ns/1ns
`include "cls_consts.svh"
module cls_status_bench;
	import cls_pkg::*;
	logic           clk, rst_n, hsel, hwrite, rd_q, rdy, resp, irq;
	logic [1:0]     htrans;
	logic [31:0]    haddr, hwdata, hrdata, seed;
	logic [31:0]    exp_q[$];
	cls_event_type  ev;
	cls_status_type st;
	int             num_errors = 0, tests_run = 0, i;
	// expected code per fault pulse, indexed by event bit
	logic [2:0]     codes[7] = '{3'h6, 3'h5, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
	cls_status cls_status_inst (.ref_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(rdy),
		.hrdata_out(hrdata), .hreadyout_out(rdy), .hresp_out(resp), .core_event_in(ev), .status_out(st),
		.status_change_irq_out(irq));
	cls_core_model cls_core_model_inst (.ref_clk_in(clk), .ev_out(ev));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task summarize;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (rdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_q <= !w;
		do @(posedge clk); while (rdy !== 1'b1);
		rd_q <= 1'b0;
	endtask
	task rd(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	// read data is taken at the data-phase edge
	always @(posedge clk) begin
		if (rd_q && rdy) begin
			chk("hrdata", exp_q.pop_front(), hrdata);
			chk("hresp", 32'(`CLS_HRESP_OKAY), 32'(resp));
		end
	end
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		summarize;
	end
	initial begin
		{rst_n, hsel, hwrite, rd_q, htrans, haddr, hwdata} = '0;
		seed = 32'h8CC3;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(`CLS_ADDR_STATUS, 32'h0);
		rd(`CLS_ADDR_CONTROL, 32'h0);
		rd(32'h40050020, 32'h0);
		bus(1'b1, `CLS_ADDR_CONTROL, 32'h4);
		rd(`CLS_ADDR_CONTROL, 32'h4);
		for (i = 0; i < 7; i++) begin
			cls_core_model_inst.pulse(i);
			rd(`CLS_ADDR_INT_ID, `CLS_INT_ID_STATUS);
			rd(`CLS_ADDR_STATUS, 32'(codes[i]));
			rd(`CLS_ADDR_INT_ID, 32'h0);
		end
		bus(1'b1, `CLS_ADDR_STATUS, 32'h7);
		rd(`CLS_ADDR_INT_ID, 32'h0);
		rd(`CLS_ADDR_STATUS, 32'h7);
		cls_core_model_inst.pulse(7);
		rd(`CLS_ADDR_STATUS, 32'h8);
		cls_core_model_inst.pulse(0);
		rd(`CLS_ADDR_STATUS, 32'hE);
		cls_core_model_inst.pulse(8);
		rd(`CLS_ADDR_STATUS, 32'h18);
		bus(1'b1, `CLS_ADDR_STATUS, 32'h0);
		bus(1'b1, `CLS_ADDR_INT_ID, 32'hFFFFFFFF);
		bus(1'b1, 32'h40050020, 32'hFFFFFFFF);
		rd(`CLS_ADDR_STATUS, 32'h0);
		repeat (4) begin
			seed = lfsr(seed);
			bus(1'b1, `CLS_ADDR_STATUS, seed);
			rd(`CLS_ADDR_STATUS, seed & 32'h1F);
		end
		bus(1'b1, `CLS_ADDR_CONTROL, 32'h0);
		cls_core_model_inst.pulse(6);
		rd(`CLS_ADDR_INT_ID, 32'h0);
		@(posedge clk);
		summarize;
	end
endmodule
bind cls_status cls_status_asserts cls_status_asserts_inst (.*);
